// ---- i2c_bus_protocol_engine.sv ----
// Two-wire bus engine: master and slave byte engine behind APB.
// Assumes SCL/SDA inputs already synchronous to clk; pins are open drain.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE_01: Second address register holds a 7-bit slave address in bits 7:1.
// RULE_02: Bit 0 of the second address register reads as zero.
// RULE_03: High timeout byte gives bits 15:8 of the SCL low limit.
// RULE_04: Low timeout byte gives bits 7:0 of the SCL low limit.
// RULE_05: Bus is free when SCL and SDA are high; master starts only then.
// RULE_06: Start is SDA falling with SCL high; it wakes all slaves.
// RULE_07: First byte is 7-bit address plus direction bit, 1 means read.
// RULE_08: Only the matching slave pulls SDA low in the ninth clock.
// RULE_09: Master never sends its own address; never master and slave at once.
// RULE_10: Losing arbitration in an address byte leaves a working slave.
// RULE_11: Bytes are 8 bits, MSB first, one SCL pulse per bit.
// RULE_12: Transmitter changes SDA only while SCL is low.
// RULE_13: Every byte has a ninth acknowledge bit driven low by receiver.
// RULE_14: Missing slave acknowledge leaves SDA high; master sees failure.
// RULE_15: Master receiver NACK ends slave transmission; slave releases SDA.
// RULE_16: After a NACK the master only stops or restarts.
// RULE_17: Stop is SDA rising with SCL high; it frees the bus.
// RULE_18: A stop after an acknowledge makes the slave release the bus.
// RULE_19: Repeated start with new address works without a stop.
// RULE_20: Driving 1 but seeing 0 loses arbitration; release, flag, no stop.
// RULE_21: SCL low lasts until every device has counted its low time.
// RULE_22: High time starts when SCL rises; first finisher pulls it low.
// RULE_23: Slave may stretch SCL after nine bits; master waits for release.
// RULE_24: SCL low timeout is off while the 16-bit limit is zero.
// RULE_25: Timeout counts at clock/64, or clock when select bit is 1.
// RULE_26: Second address matches only while its enable bit is 1.
// RULE_27: SCL and SDA are only driven low or released.
module i2c_bus_protocol_engine (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [i2c_engine_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                       pwdata,
  output var  logic [31:0]                       prdata,
  output var  logic                              pready,
  output var  logic                              pslverr,
  // Bus pins
  input  wire logic                              sclIn,
  output var  logic                              sclOut,
  output var  logic                              sclOe,
  input  wire logic                              sdaIn,
  output var  logic                              sdaOut,
  output var  logic                              sdaOe
);
  import i2c_engine_pkg::*;

  // Software registers and flags
  logic [6:0]  ownAddr_q, smbAddr_q;
  logic [7:0]  halfDiv_q, txData_q, rxData_q, sltHigh_q, sltLow_q;
  logic        txNack_q, toSel_q, secondEn_q;
  logic        byteDone_q, arbLost_q, refused_q, lowTo_q, rxNack_q, busy_q;
  // Master sequencer
  mstate_t     mState_q;
  logic [7:0]  divCnt_q, mShift_q;
  logic [3:0]  bitCnt_q;
  logic        mRead_q, mAddrPh_q, mSdaLow_q, mAck_q;
  // Slave engine
  logic [7:0]  sShift_q;
  logic [3:0]  sCnt_q;
  logic        sActive_q, sAddrPh_q, sAddressed_q, sTx_q;
  logic        sSdaLow_q, sStretch_q, sNack_q;
  // Line history and timeout
  logic        sclPrev_q, sdaPrev_q;
  logic [5:0]  preCnt_q;
  logic [15:0] toCnt_q;
  logic [31:0] rdData;

  function automatic logic idxKnown(input logic [5:0] i);
    case (i)
      IDX_OWN_ADDR, IDX_HALF_DIV, IDX_CTRL, IDX_STATUS, IDX_DATA,
      IDX_CMD, IDX_SMB_A2, IDX_SLT_HIGH, IDX_SLT_LOW: idxKnown = 1'b1;
      default: idxKnown = 1'b0;
    endcase
  endfunction

  // Bus decode; writes land on the access edge that sees pready high
  wire [5:0] idx     = paddr[7:2];
  wire       setup   = psel && !penable;
  wire       wrEn    = psel && penable && pready && pwrite && !pslverr;
  wire       wrCtrl  = wrEn && (idx == IDX_CTRL);
  wire       wrStat  = wrEn && (idx == IDX_STATUS);
  wire       cmdHit  = wrEn && (idx == IDX_CMD);
  wire       cmdStart = cmdHit && pwdata[CMD_START];
  wire       cmdStop  = cmdHit && pwdata[CMD_STOP];
  wire       cmdXfer  = cmdHit && pwdata[CMD_XFER];

  // Line events seen on the sampled pins
  wire startDet = sclIn && sclPrev_q && sdaPrev_q && !sdaIn;
  wire stopDet  = sclIn && sclPrev_q && !sdaPrev_q && sdaIn;
  wire sclRise  = sclIn && !sclPrev_q;
  wire sclFall  = !sclIn && sclPrev_q;

  // Master decisions
  wire mstActive = (mState_q != M_IDLE);
  wire ownHit    = (txData_q[7:1] == ownAddr_q);
  wire busFree   = !busy_q && sclIn && sdaIn;
  wire startOk   = cmdStart && !ownHit &&                 // RULE_09
                   ((mState_q == M_IDLE && busFree) ||    // RULE_05
                    mState_q == M_WAIT);                  // RULE_19
  wire xferBad   = cmdXfer && mState_q == M_WAIT && rxNack_q;
  wire refuseEv  = (cmdStart && !startOk) || xferBad;     // RULE_16
  wire mTxBit    = mAddrPh_q || !mRead_q;
  wire stepDone  = (divCnt_q == halfDiv_q);
  wire arbEv     = mState_q == M_HIGH && sclIn && mTxBit &&
                   bitCnt_q < 4'h8 && !mSdaLow_q && !sdaIn;  // RULE_20
  wire highDone  = mState_q == M_HIGH &&
                   ((sclIn && stepDone) ||
                    (!sclIn && divCnt_q != 8'h00));      // RULE_22
  wire mDoneEv   = highDone && bitCnt_q == 4'h8;
  wire mRxLoad   = mDoneEv && mRead_q && !mAddrPh_q;
  wire mSclLow   = mState_q == M_LOW || mState_q == M_WAIT ||
                   mState_q == M_RS1 || mState_q == M_SP1;
  // Level to put on SDA for the current bit, ninth bit is acknowledge
  wire bitLow    = (bitCnt_q < 4'h8) ? (mTxBit && !mShift_q[7])
                                     : (!mTxBit && !txNack_q); // RULE_13

  // Slave decisions
  wire sMatch    = !mstActive &&                                 // RULE_09
                   (sShift_q[7:1] == ownAddr_q ||
                    (secondEn_q && sShift_q[7:1] == smbAddr_q)); // RULE_26
  wire sBusy     = sActive_q && !startDet && !stopDet;
  wire sEndByTx  = sTx_q && !sAddrPh_q && sNack_q;
  wire sDoneEv   = sBusy && sclFall && sCnt_q == 4'h8 && !sEndByTx;
  wire sRxLoad   = sBusy && sclFall && sCnt_q == 4'h7 &&
                   !sAddrPh_q && !sTx_q;

  // Timeout tick and limit
  wire [15:0] sltVal = {sltHigh_q, sltLow_q};              // RULE_03 RULE_04
  wire toTick  = toSel_q || preCnt_q == TO_PRESCALE_LAST;  // RULE_25
  wire lowToEv = !sclIn && sltVal != 16'h0000 && toTick &&
                 (toCnt_q + 16'h0001) == sltVal;           // RULE_24

  // Read mux
  always_comb begin
    rdData = 32'h0000_0000;
    case (idx)
      IDX_OWN_ADDR: rdData[7:ADDR_LSB] = ownAddr_q;
      IDX_HALF_DIV: rdData[7:0] = halfDiv_q;
      IDX_CTRL: begin
        rdData[CT_TXNACK]    = txNack_q;
        rdData[CT_TO_SEL]    = toSel_q;
        rdData[CT_SECOND_EN] = secondEn_q;
      end
      IDX_STATUS: begin
        rdData[ST_BUSY]      = busy_q;
        rdData[ST_MASTER]    = mstActive;
        rdData[ST_ADDRESSED] = sAddressed_q;
        rdData[ST_SLV_TX]    = sTx_q;
        rdData[ST_RX_NACK]   = rxNack_q;
        rdData[ST_BYTE_DONE] = byteDone_q;
        rdData[ST_ARB_LOST]  = arbLost_q;
        rdData[ST_LOW_TO]    = lowTo_q;
        rdData[ST_REFUSED]   = refused_q;
      end
      IDX_DATA:     rdData[7:0] = rxData_q;
      IDX_SMB_A2:   rdData[7:ADDR_LSB] = smbAddr_q;  // RULE_02
      IDX_SLT_HIGH: rdData[7:0] = sltHigh_q;
      IDX_SLT_LOW:  rdData[7:0] = sltLow_q;
      default:      rdData = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait-free access phase, error on unmapped words
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !idxKnown(idx) || paddr[1:0] != 2'h0;
      prdata  <= pwrite ? 32'h0000_0000 : rdData;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Plain registers; all read back except txData_q, whose word reads rxData_q
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ownAddr_q  <= RST_OWN_ADDR;
      halfDiv_q  <= RST_HALF_DIV;
      txNack_q   <= 1'b0;
      toSel_q    <= 1'b0;
      secondEn_q <= 1'b0;
      txData_q   <= 8'h00;
      smbAddr_q  <= RST_SMB_ADDR;
      sltHigh_q  <= RST_SLT_BYTE;
      sltLow_q   <= RST_SLT_BYTE;
    end else if (wrEn) begin
      case (idx)
        IDX_OWN_ADDR: ownAddr_q <= pwdata[7:ADDR_LSB];
        IDX_HALF_DIV: halfDiv_q <= pwdata[7:0];
        IDX_CTRL: begin
          txNack_q   <= pwdata[CT_TXNACK];
          toSel_q    <= pwdata[CT_TO_SEL];
          secondEn_q <= pwdata[CT_SECOND_EN];
        end
        IDX_DATA:     txData_q  <= pwdata[7:0];
        IDX_SMB_A2:   smbAddr_q <= pwdata[7:ADDR_LSB];  // RULE_01
        IDX_SLT_HIGH: sltHigh_q <= pwdata[7:0];         // RULE_03
        IDX_SLT_LOW:  sltLow_q  <= pwdata[7:0];         // RULE_04
        default: ;
      endcase
    end
  end

  // Sticky flags: a hardware set wins over a write-one clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byteDone_q <= 1'b0;
      arbLost_q  <= 1'b0;
      refused_q  <= 1'b0;
      lowTo_q    <= 1'b0;
      rxData_q   <= 8'h00;
    end else begin
      if (mDoneEv || sDoneEv) byteDone_q <= 1'b1;
      else if (wrStat && pwdata[ST_BYTE_DONE]) byteDone_q <= 1'b0;
      if (arbEv) arbLost_q <= 1'b1;                      // RULE_20
      else if (wrStat && pwdata[ST_ARB_LOST]) arbLost_q <= 1'b0;
      if (refuseEv) refused_q <= 1'b1;
      else if (wrStat && pwdata[ST_REFUSED]) refused_q <= 1'b0;
      if (lowToEv) lowTo_q <= 1'b1;
      else if (wrStat && pwdata[ST_LOW_TO]) lowTo_q <= 1'b0;
      if (mRxLoad) rxData_q <= mShift_q;
      else if (sRxLoad) rxData_q <= sShift_q;
    end
  end

  // Line history and bus busy state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      busy_q    <= 1'b0;
    end else begin
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
      if (startDet) busy_q <= 1'b1;                      // RULE_06
      else if (stopDet) busy_q <= 1'b0;                  // RULE_17
    end
  end

  // Master sequencer; counts wait while SCL is held low by others
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mState_q  <= M_IDLE;
      divCnt_q  <= 8'h00;
      bitCnt_q  <= 4'h0;
      mShift_q  <= 8'h00;
      mRead_q   <= 1'b0;
      mAddrPh_q <= 1'b0;
      mAck_q    <= 1'b1;
      rxNack_q  <= 1'b0;
    end else begin
      case (mState_q)
        M_IDLE: begin
          divCnt_q <= 8'h00;
          if (startOk) begin
            mState_q  <= M_START;
            mShift_q  <= txData_q;
            mRead_q   <= txData_q[0];                    // RULE_07
            mAddrPh_q <= 1'b1;
          end
        end
        M_START, M_LOW, M_RS1, M_SP1: begin
          if (stepDone) begin
            divCnt_q <= 8'h00;
            case (mState_q)
              M_START: mState_q <= M_LOW;
              M_LOW:   mState_q <= M_HIGH;
              M_RS1:   mState_q <= M_RS2;
              default: mState_q <= M_SP2;
            endcase
            if (mState_q == M_START) bitCnt_q <= 4'h0;
          end else begin
            divCnt_q <= divCnt_q + 8'h01;
          end
        end
        M_HIGH: begin
          if (arbEv) begin
            mState_q <= M_IDLE;                          // RULE_10 RULE_20
          end else if (highDone) begin
            divCnt_q <= 8'h00;                           // RULE_22
            if (bitCnt_q == 4'h8) begin
              mState_q  <= M_WAIT;
              mAddrPh_q <= 1'b0;
              rxNack_q  <= mAck_q;                       // RULE_14
            end else begin
              bitCnt_q <= bitCnt_q + 4'h1;               // RULE_11
              mState_q <= M_LOW;
            end
          end else if (sclIn) begin                      // RULE_21 RULE_23
            divCnt_q <= divCnt_q + 8'h01;
            if (divCnt_q == 8'h00 && bitCnt_q < 4'h8)
              mShift_q <= {mShift_q[6:0], sdaIn};        // RULE_11
            if (divCnt_q == 8'h00 && bitCnt_q == 4'h8)
              mAck_q <= sdaIn;                           // RULE_13
          end
        end
        M_WAIT: begin
          divCnt_q <= 8'h00;
          if (startOk) begin
            mState_q  <= M_RS1;                          // RULE_19
            mShift_q  <= txData_q;
            mRead_q   <= txData_q[0];
            mAddrPh_q <= 1'b1;
          end else if (cmdStop) begin
            mState_q <= M_SP1;                           // RULE_16
          end else if (cmdXfer && !rxNack_q) begin
            mState_q <= M_LOW;
            bitCnt_q <= 4'h0;
            if (!mRead_q) mShift_q <= txData_q;
          end
        end
        M_RS2, M_SP2: begin
          if (sclIn && stepDone) begin
            divCnt_q <= 8'h00;
            mState_q <= (mState_q == M_RS2) ? M_START : M_IDLE;
          end else if (sclIn) begin
            divCnt_q <= divCnt_q + 8'h01;                // RULE_21
          end
        end
        default: mState_q <= M_IDLE;
      endcase
    end
  end

  // Master SDA level; in M_LOW, M_WAIT, M_RS1 and M_SP1 new values only once SCL is seen low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mSdaLow_q <= 1'b0;
    end else begin
      case (mState_q)
        M_START, M_SP2: mSdaLow_q <= 1'b1;               // RULE_06 RULE_17
        M_IDLE, M_RS2:  mSdaLow_q <= 1'b0;
        M_LOW:    if (!sclIn) mSdaLow_q <= bitLow;       // RULE_12
        M_WAIT, M_RS1: if (!sclIn) mSdaLow_q <= 1'b0;
        M_SP1:    if (!sclIn) mSdaLow_q <= 1'b1;
        M_HIGH:   if (arbEv) mSdaLow_q <= 1'b0;
        default:  mSdaLow_q <= 1'b0;
      endcase
    end
  end

  // Slave engine: samples on SCL rise, changes SDA after SCL fall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sActive_q    <= 1'b0;
      sAddrPh_q    <= 1'b0;
      sAddressed_q <= 1'b0;
      sTx_q        <= 1'b0;
      sSdaLow_q    <= 1'b0;
      sStretch_q   <= 1'b0;
      sNack_q      <= 1'b0;
      sCnt_q       <= 4'h0;
      sShift_q     <= 8'h00;
    end else if (stopDet) begin
      sActive_q    <= 1'b0;                              // RULE_17 RULE_18
      sAddressed_q <= 1'b0;
      sTx_q        <= 1'b0;
      sSdaLow_q    <= 1'b0;
      sStretch_q   <= 1'b0;
    end else if (startDet) begin
      sActive_q    <= 1'b1;                              // RULE_06
      sAddrPh_q    <= 1'b1;
      sAddressed_q <= 1'b0;
      sTx_q        <= 1'b0;
      sSdaLow_q    <= 1'b0;
      sStretch_q   <= 1'b0;
      sCnt_q       <= 4'hf;  // Start's own SCL fall is not a bit
    end else if (sActive_q) begin
      if (sStretch_q && !byteDone_q) begin
        sStretch_q <= 1'b0;                              // RULE_23
        if (sTx_q) begin
          sShift_q  <= txData_q;
          sSdaLow_q <= !txData_q[7];
        end
      end
      if (sclRise && sCnt_q < 4'h8)
        sShift_q <= {sShift_q[6:0], sdaIn};              // RULE_11
      if (sclRise && sCnt_q == 4'h8)
        sNack_q <= sdaIn;
      if (sclFall) begin
        if (sCnt_q == 4'h7) begin
          sCnt_q <= 4'h8;
          if (sAddrPh_q) begin
            if (sMatch) begin
              sSdaLow_q    <= 1'b1;                      // RULE_08
              sAddressed_q <= 1'b1;
              sTx_q        <= sShift_q[0];               // RULE_07
            end else begin
              sActive_q <= 1'b0;
            end
          end else begin
            sSdaLow_q <= !sTx_q && !txNack_q;            // RULE_13
          end
        end else if (sCnt_q == 4'h8) begin
          sCnt_q    <= 4'h0;
          sAddrPh_q <= 1'b0;
          sSdaLow_q <= 1'b0;
          if (sEndByTx) sActive_q <= 1'b0;               // RULE_15
          else sStretch_q <= 1'b1;
        end else begin
          sCnt_q <= sCnt_q + 4'h1;
          if (sTx_q) sSdaLow_q <= !sShift_q[7];          // RULE_12
        end
      end
    end
  end

  // SCL low timeout counter with /64 prescaler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      preCnt_q <= 6'h00;
      toCnt_q  <= 16'h0000;
    end else begin
      preCnt_q <= preCnt_q + 6'h01;
      if (sclIn || sltVal == 16'h0000) toCnt_q <= 16'h0000;  // RULE_24
      else if (toTick && toCnt_q != sltVal) toCnt_q <= toCnt_q + 16'h0001;
    end
  end

  // Pin drivers: output level is always low, only the enable moves
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe  <= 1'b0;
      sdaOe  <= 1'b0;
    end else begin
      sclOut <= 1'b0;                                    // RULE_27
      sdaOut <= 1'b0;
      sclOe  <= mSclLow || sStretch_q;
      sdaOe  <= mSdaLow_q || sSdaLow_q;
    end
  end

  // Checks
  property p_a2_zero;
    @(posedge clk) disable iff (!reset_n)
    (setup && !pwrite && idx == IDX_SMB_A2) |=> (prdata[0] == 1'b0);
  endproperty
  a_a2_zero: assert property (p_a2_zero) else $error("A2 bit0 not 0"); // RULE_02

  property p_open_drain;
    @(posedge clk) disable iff (!reset_n)
    !sclOut && !sdaOut;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Pin driven high"); // RULE_27

  property p_start_free;
    @(posedge clk) disable iff (!reset_n)
    (mState_q == M_IDLE && startOk) |-> (sclIn && sdaIn && !busy_q);
  endproperty
  a_start_free: assert property (p_start_free) else $error("Start on busy bus"); // RULE_05

  property p_sda_stable_high;
    @(posedge clk) disable iff (!reset_n)
    (mState_q == M_HIGH && $past(mState_q) == M_HIGH && !arbEv)
      |-> $stable(mSdaLow_q);
  endproperty
  a_sda_stable_high: assert property (p_sda_stable_high) else $error("SDA moved in high"); // RULE_12

  property p_arb_lost;
    @(posedge clk) disable iff (!reset_n)
    arbEv |=> (mState_q == M_IDLE && arbLost_q && !mSdaLow_q) ##1 !sdaOe;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("Arbitration loss mishandled"); // RULE_20

  property p_timeout_off;
    @(posedge clk) disable iff (!reset_n)
    (sltVal == 16'h0000 && !lowTo_q) |=> !lowTo_q;
  endproperty
  a_timeout_off: assert property (p_timeout_off) else $error("Timeout while disabled"); // RULE_24

  property p_stop_release;
    @(posedge clk) disable iff (!reset_n)
    stopDet |=> (!sActive_q && !sSdaLow_q && !sStretch_q) ##1 !sdaOe || mstActive;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("Slave held bus after stop"); // RULE_18

  property p_no_dual_role;
    @(posedge clk) disable iff (!reset_n)
    !(mstActive && sAddressed_q);
  endproperty
  a_no_dual_role: assert property (p_no_dual_role) else $error("Master and slave at once"); // RULE_09

  property p_nack_refused;
    @(posedge clk) disable iff (!reset_n)
    xferBad |=> (mState_q == M_WAIT && refused_q);
  endproperty
  a_nack_refused: assert property (p_nack_refused) else $error("Transfer after NACK"); // RULE_16

  property p_low_wait;
    @(posedge clk) disable iff (!reset_n)
    (mState_q == M_HIGH && !sclIn && divCnt_q == 8'h00) |=> mState_q == M_HIGH;
  endproperty
  a_low_wait: assert property (p_low_wait) else $error("Master ignored held SCL"); // RULE_21

endmodule
`default_nettype wire

// ---- i2c_engine_pkg.sv ----
// Constants, register map and state codes of the two-wire bus engine.
// Assumes a 32-bit APB slave port with word-aligned registers.
package i2c_engine_pkg;

  // APB address width in bits
  localparam int unsigned APB_AW = 8;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_OWN_ADDR = 6'h00;
  localparam logic [5:0] IDX_HALF_DIV = 6'h01;
  localparam logic [5:0] IDX_CTRL     = 6'h02;
  localparam logic [5:0] IDX_STATUS   = 6'h03;
  localparam logic [5:0] IDX_DATA     = 6'h04;
  localparam logic [5:0] IDX_CMD      = 6'h05;
  localparam logic [5:0] IDX_SMB_A2   = 6'h09;
  localparam logic [5:0] IDX_SLT_HIGH = 6'h0a;
  localparam logic [5:0] IDX_SLT_LOW  = 6'h0b;

  // Field positions
  localparam int unsigned ADDR_LSB     = 1;  // 7-bit address in bits 7:1
  localparam int unsigned CT_TXNACK    = 0;
  localparam int unsigned CT_TO_SEL    = 1;
  localparam int unsigned CT_SECOND_EN = 2;
  localparam int unsigned CMD_START    = 0;
  localparam int unsigned CMD_STOP     = 1;
  localparam int unsigned CMD_XFER     = 2;
  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_MASTER    = 1;
  localparam int unsigned ST_ADDRESSED = 2;
  localparam int unsigned ST_SLV_TX    = 3;
  localparam int unsigned ST_RX_NACK   = 4;
  localparam int unsigned ST_BYTE_DONE = 5;
  localparam int unsigned ST_ARB_LOST  = 6;
  localparam int unsigned ST_LOW_TO    = 7;
  localparam int unsigned ST_REFUSED   = 8;

  // Reset values
  localparam logic [7:0] RST_HALF_DIV = 8'hfa;
  localparam logic [6:0] RST_OWN_ADDR = 7'h7f;
  localparam logic [6:0] RST_SMB_ADDR = 7'h00;
  localparam logic [7:0] RST_SLT_BYTE = 8'h00;

  // Timeout prescaler: bus clock divided by 64
  localparam logic [5:0] TO_PRESCALE_LAST = 6'h3f;

  // Master sequencer states
  typedef enum logic [8:0] {
    M_IDLE  = 9'h001,
    M_START = 9'h002,
    M_LOW   = 9'h004,
    M_HIGH  = 9'h008,
    M_WAIT  = 9'h010,
    M_RS1   = 9'h020,
    M_RS2   = 9'h040,
    M_SP1   = 9'h080,
    M_SP2   = 9'h100
  } mstate_t;

endpackage

// ---- i2c_slave_model.sv ----
// Behavioural bus target, write direction only.
// Assumes the bench resolves wired-AND lines with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_model #(parameter logic [6:0] SLV = 7'h3a) (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output var  logic       sdaPull,
  // Last data byte taken
  output var  logic [7:0] rxByte
);
  int         n = 0;
  logic [7:0] sh = 8'h00;
  logic       adr = 1'b0;
  logic       hit = 1'b0;
  initial sdaPull = 1'b0;
  initial rxByte = 8'h00;
  // Start re-arms the address phase; stop drops selection
  always @(negedge sda) if (scl) begin
    n = 0;
    adr = 1'b1;
    hit = 1'b0;
  end
  always @(posedge sda) if (scl) hit = 1'b0;
  // Sample only while SCL is high
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    n++;
  end
  // Ack placed and removed with SCL low, so no false start or stop
  always @(negedge scl) begin
    sdaPull = 1'b0;
    if (n == 8) begin
      if (adr) hit = (sh[7:1] == SLV);
      else rxByte = sh;
      adr = 1'b0;
      sdaPull = hit;
    end else if (n == 9) n = 0;
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Bench: APB register checks and bus transfers to a target model.
// Assumes pull-ups on both lines; the model never stretches SCL.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import i2c_engine_pkg::*;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, err;
  logic        sdaPull, extPull = 1'b0;
  logic [7:0]  rxByte;
  int          errCount = 0, checksDone = 0, cyc = 0;
  // Wired-AND with pull-ups
  wire logic   scl = ~sclOe;
  // extPull plays a rival master that holds SDA low
  wire logic   sda = ~sdaOe & ~sdaPull & ~extPull;
  i2c_bus_protocol_engine u_i2c_bus_protocol_engine (.clk, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sclIn(scl), .sclOut, .sclOe, .sdaIn(sda), .sdaOut, .sdaOe);
  i2c_slave_model u_i2c_slave_model (.scl(scl), .sda(sda),
    .sdaPull(sdaPull), .rxByte(rxByte));
  initial forever #2.5 clk = ~clk;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle cycle follows so psel never toggles twice
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    // pready is read at the edge, before the design updates it
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Poll status until byte done, bounded
  task waitDone;
    repeat (400) begin
      apb(1'b0, 8'h0c, 32'h0);
      if (rd[ST_BYTE_DONE] === 1'b1) break;
    end
  endtask
  always @(posedge clk) if (++cyc == 60000) begin
    errCount++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(0, 8'h24, 0); chk(rd, 32'h0);
    apb(1, 8'h24, 32'hff); apb(0, 8'h24, 0); chk(rd, 32'hfe);
    apb(1, 8'h28, 32'h12); apb(0, 8'h28, 0); chk(rd, 32'h12);
    apb(1, 8'h2c, 32'h34); apb(0, 8'h2c, 0); chk(rd, 32'h34);
    apb(0, 8'h3c, 0);
    chk({31'h0, err}, 32'h1);
    apb(1, 8'h28, 0);
    apb(1, 8'h2c, 0);
    $display("registers done");
    apb(1, 8'h04, 32'h4);
    apb(1, 8'h10, 32'h74); apb(1, 8'h14, 1); waitDone;
    chk(rd & 32'h1b7, 32'h23);
    apb(1, 8'h0c, 32'h20); apb(1, 8'h10, 32'ha5); apb(1, 8'h14, 4);
    waitDone; chk(rd & 32'h10, 0); chk({24'h0, rxByte}, 32'ha5);
    apb(1, 8'h0c, 32'h20); apb(1, 8'h14, 2);
    repeat (20) apb(0, 8'h0c, 0);
    chk(rd & 32'h3, 0); chk({30'h0, scl, sda}, 32'h3);
    chk({30'h0, sclOut, sdaOut}, 32'h0);
    $display("write transfer done");
    apb(1, 8'h10, 32'h20); apb(1, 8'h14, 1); waitDone;
    chk(rd & 32'h10, 32'h10);
    apb(1, 8'h0c, 32'h1e0); apb(1, 8'h14, 4); apb(0, 8'h0c, 0);
    chk(rd & 32'h100, 32'h100);
    apb(1, 8'h0c, 32'h1e0); apb(1, 8'h10, 32'hfe); apb(1, 8'h14, 1);
    apb(0, 8'h0c, 0); chk(rd & 32'h120, 32'h100);
    apb(1, 8'h0c, 32'h1e0); apb(1, 8'h10, 32'h74); apb(1, 8'h14, 1);
    waitDone; chk(rd & 32'h10, 0);
    $display("nack and restart done");
    // Rival pulls SDA while SCL is held low; our first data bit is a 1
    extPull <= 1'b1;
    apb(1, 8'h0c, 32'h1e0); apb(1, 8'h10, 32'ha5); apb(1, 8'h14, 4);
    repeat (20) apb(0, 8'h0c, 0);
    chk(rd & 32'h42, 32'h40); chk({31'h0, sdaOe}, 32'h0);
    extPull <= 1'b0;
    $display("arbitration done");
    apb(1, 8'h0c, 32'h1e0); apb(1, 8'h2c, 2); apb(1, 8'h08, 2);
    apb(1, 8'h10, 32'h74); apb(1, 8'h14, 1);
    waitDone; chk(rd & 32'h80, 32'h80);
    apb(1, 8'h14, 2);
    $display("timeout done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
